/* core/ptimer_pkg.sv */
// Shared constants, register map and carrier types of the quad timer.
// Assumes a 32-bit APB slave and oscillator clocks sampled on pclk.
package ptimer_pkg;

  // ==========================================================
  // Bus
  localparam int ADDR_W = 18;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] IDX_PRIO = 16'hFF21;
  localparam logic [15:0] IDX_EN_A = 16'hFF23;
  localparam logic [15:0] IDX_FLAG_A = 16'hFF25;
  localparam logic [15:0] IDX_EN_B = 16'hFF26;
  localparam logic [15:0] IDX_FLAG_B = 16'hFF27;
  localparam logic [1:0][15:0] IDX_PAIR = {16'hFF38, 16'hFF30};
  localparam logic [3:0][15:0] IDX_CTL = {16'hFF3A, 16'hFF39, 16'hFF32, 16'hFF31};
  localparam logic [3:0][15:0] IDX_RLD = {16'hFF3C, 16'hFF3B, 16'hFF34, 16'hFF33};
  localparam logic [3:0][15:0] IDX_CNT = {16'hFF3E, 16'hFF3D, 16'hFF36, 16'hFF35};

  // ==========================================================
  // Field positions
  localparam int CTL_RUN = 0;
  localparam int CTL_PRESET = 1;
  localparam int CTL_REPEAT = 2;
  localparam int CTL_RATIO = 3;
  localparam int CTL_POL = 5;
  localparam int CTL_FUNC = 6;
  localparam int CTL_EVENT = 7;
  localparam int PAIR_SRC_LO = 0;
  localparam int PAIR_SRC_HI = 1;
  localparam int PAIR_JOIN = 4;
  localparam int PRIO01_POS = 2;
  localparam int PRIO23_POS = 4;
  localparam int IRQ_LO_BIT = 6;
  localparam int IRQ_HI_BIT = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RELOAD_RST = 8'hFF;
  localparam logic [7:0] COUNT_RST = 8'hFF;

  // ==========================================================
  // Timing: sample and latch counts in slow oscillator periods, reject count in sample ticks
  localparam int SLOW_OSC_HZ = 32768;
  localparam int SAMPLE_HZ = 2048;
  localparam logic [3:0] SAMPLE_LAST = 4'(SLOW_OSC_HZ / SAMPLE_HZ - 1);
  localparam int LATCH_HOLD_US = 977;
  localparam logic [5:0] LATCH_LAST = 6'(LATCH_HOLD_US * SLOW_OSC_HZ / 1000000 - 1);
  localparam logic [1:0] REJECT_LAST = 2'h1;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_e;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_s;

  typedef struct packed {
    logic event_mode;
    logic func_sel;
    logic pol_sel;
    logic [1:0] ratio;
    logic repeat_sel;
    logic run;
  } timer_ctl_s;

  typedef struct packed {
    logic [7:0] reload;
    logic [7:0] count;
    logic [5:0] div;
    logic src_sel;
    logic flag;
    logic irq_en;
  } timer_s;

  typedef struct packed {
    logic joined;
    logic [1:0] prio;
    logic latch_valid;
    logic [7:0] latch;
    logic [5:0] age;
  } pair_s;

  // ==========================================================
  // Prescaler mask for divide by 1, 4, 16, 64
  function automatic logic [5:0] ratio_mask(input logic [1:0] r);
    case (r)
      2'h3: return 6'h3F;
      2'h2: return 6'h0F;
      2'h1: return 6'h03;
      default: return 6'h00;
    endcase
  endfunction : ratio_mask

endpackage : ptimer_pkg

/* core/pin_sync.sv */
// Three-stage synchroniser with level and edge pulses.
// Assumes an input asynchronous to pclk.
`timescale 1ns/1ps
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output ptimer_pkg::pin_s sync
);

  typedef struct packed {
    logic [2:0] chain;
    ptimer_pkg::pin_s out;
  } sync_state_s;

  sync_state_s s;
  sync_state_s n;

  // ==========================================================
  // Next state
  always_comb
  begin
    n = s;
    n.chain = {s.chain[1:0], pin};
    if (s.chain[1] == s.chain[2])
    begin
      n.out.level = s.chain[2];
    end
    n.out.rise = n.out.level & ~s.out.level;
    n.out.fall = ~n.out.level & s.out.level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign sync = s.out;

endmodule : pin_sync

/* core/ptimer_quad.sv */
// Four 8-bit down-counting timers, pairable to 16 bits, behind APB.
// Assumes oscillator clocks and event pins asynchronous to pclk.
`timescale 1ns/1ps
module ptimer_quad (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ptimer_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_osc_clock,
  input wire logic fast_osc_clock,
  input wire logic event_pin_a,
  input wire logic event_pin_b,
  output logic [1:0] irq_req,
  output logic [1:0] irq_level_01,
  output logic [1:0] irq_level_23
);

  typedef struct packed {
    ptimer_pkg::bus_state_e bus;
    ptimer_pkg::timer_ctl_s [3:0] ctl;
    ptimer_pkg::timer_s [3:0] tmr;
    ptimer_pkg::pair_s [1:0] pair;
    logic [1:0] filt;
    logic [1:0][1:0] rej;
    logic [3:0] sample_div;
    logic [31:0] prdata;
    logic pslverr;
    logic [1:0] irq_req;
  } state_s;

  state_s s;
  state_s n;

  ptimer_pkg::pin_s slow;
  ptimer_pkg::pin_s fast;
  ptimer_pkg::pin_s pin_a;
  ptimer_pkg::pin_s pin_b;
  ptimer_pkg::pin_s pin;
  logic [15:0] idx;
  logic cap;
  logic wr;
  logic hit;
  logic [7:0] wb;
  logic [7:0] rbyte;
  logic [3:0] tick;
  logic [3:0] uf;
  logic [1:0] frise;
  logic [1:0] ffall;
  logic pre_edge;
  logic sample_tick;
  logic [8:0] step;

  // ==========================================================
  // Synchronisers
  pin_sync u_slow (.pclk(pclk), .presetn(presetn), .pin(slow_osc_clock), .sync(slow));
  pin_sync u_fast (.pclk(pclk), .presetn(presetn), .pin(fast_osc_clock), .sync(fast));
  pin_sync u_pin_a (.pclk(pclk), .presetn(presetn), .pin(event_pin_a), .sync(pin_a));
  pin_sync u_pin_b (.pclk(pclk), .presetn(presetn), .pin(event_pin_b), .sync(pin_b));

  // ==========================================================
  // Helpers
  function automatic logic [8:0] count_step(input logic [7:0] c, input logic [7:0] r);
    return (c == 8'h00) ? {1'b1, r} : {1'b0, c - 8'h01};
  endfunction : count_step

  function automatic logic [7:0] ctl_byte(input ptimer_pkg::timer_ctl_s c, input logic lower);
    logic [7:0] b;
    b = 8'h00;
    if (lower)
    begin
      b[ptimer_pkg::CTL_EVENT] = c.event_mode;
      b[ptimer_pkg::CTL_FUNC] = c.func_sel;
      b[ptimer_pkg::CTL_POL] = c.pol_sel;
    end
    b[ptimer_pkg::CTL_RATIO +: 2] = c.ratio;
    b[ptimer_pkg::CTL_REPEAT] = c.repeat_sel;
    b[ptimer_pkg::CTL_RUN] = c.run;
    return b;
  endfunction : ctl_byte

  // ==========================================================
  // Next state
  always_comb
  begin
    n = s;
    idx = paddr[ptimer_pkg::ADDR_W-1:2];
    cap = psel & penable & (s.bus == ptimer_pkg::BUS_IDLE);
    wr = psel & penable & pwrite & (s.bus == ptimer_pkg::BUS_ACK);
    wb = pwdata[7:0];
    rbyte = 8'h00;
    hit = 1'b0;
    tick = 4'h0;
    uf = 4'h0;
    frise = 2'h0;
    ffall = 2'h0;
    pre_edge = 1'b0;
    pin = pin_a;
    step = 9'h000;

    // One wait state per transfer
    case (s.bus)
      ptimer_pkg::BUS_IDLE:
      begin
        if (psel & penable)
        begin
          n.bus = ptimer_pkg::BUS_ACK;
        end
      end
      ptimer_pkg::BUS_ACK: n.bus = ptimer_pkg::BUS_IDLE;
      default: n.bus = ptimer_pkg::BUS_IDLE;
    endcase

    // Internal 2048 Hz sample tick
    sample_tick = slow.rise & (s.sample_div == ptimer_pkg::SAMPLE_LAST);
    if (slow.rise)
    begin
      n.sample_div = s.sample_div + 4'h1;
    end

    // Noise rejecter per event pin
    for (int p = 0; p < 2; p++)
    begin
      pin = (p == 0) ? pin_a : pin_b;
      if (pin.level == s.filt[p])
      begin
        n.rej[p] = 2'h0;
      end
      else if (sample_tick)
      begin
        if (s.rej[p] == ptimer_pkg::REJECT_LAST)
        begin
          n.filt[p] = pin.level;
          n.rej[p] = 2'h0;
        end
        else
        begin
          n.rej[p] = s.rej[p] + 2'h1;
        end
      end
      frise[p] = n.filt[p] & ~s.filt[p];
      ffall[p] = ~n.filt[p] & s.filt[p];
    end

    // Prescalers
    for (int i = 0; i < 4; i++)
    begin
      pre_edge = s.tmr[i].src_sel ? fast.rise : slow.rise;
      if (pre_edge)
      begin
        n.tmr[i].div = s.tmr[i].div + 6'h01;
      end
      tick[i] = pre_edge & ((s.tmr[i].div & ptimer_pkg::ratio_mask(s.ctl[i].ratio))
                == ptimer_pkg::ratio_mask(s.ctl[i].ratio));
    end

    // Counting per pair
    for (int p = 0; p < 2; p++)
    begin
      pin = (p == 0) ? pin_a : pin_b;
      if (s.ctl[2*p].event_mode)
      begin
        // Prescaler and clock select bypassed
        if (s.ctl[2*p].func_sel)
        begin
          tick[2*p] = s.ctl[2*p].pol_sel ? frise[p] : ffall[p];
        end
        else
        begin
          tick[2*p] = s.ctl[2*p].pol_sel ? pin.rise : pin.fall;
        end
      end
      else if (s.ctl[2*p].func_sel)
      begin
        tick[2*p] = tick[2*p] & (pin.level == s.ctl[2*p].pol_sel);
      end

      if (tick[2*p] & s.ctl[2*p].run)
      begin
        step = count_step(s.tmr[2*p].count, s.tmr[2*p].reload);
        uf[2*p] = step[8];
        n.tmr[2*p].count = step[7:0];
      end

      if (s.pair[p].joined)
      begin
        if (uf[2*p])
        begin
          step = count_step(s.tmr[2*p+1].count, s.tmr[2*p+1].reload);
          uf[2*p+1] = step[8];
          n.tmr[2*p+1].count = step[7:0];
        end
        if (uf[2*p+1] & ~s.ctl[2*p].repeat_sel)
        begin
          n.ctl[2*p].run = 1'b0;
        end
      end
      else
      begin
        if (tick[2*p+1] & s.ctl[2*p+1].run)
        begin
          step = count_step(s.tmr[2*p+1].count, s.tmr[2*p+1].reload);
          uf[2*p+1] = step[8];
          n.tmr[2*p+1].count = step[7:0];
        end
        for (int k = 0; k < 2; k++)
        begin
          if (uf[2*p+k] & ~s.ctl[2*p+k].repeat_sel)
          begin
            n.ctl[2*p+k].run = 1'b0;
          end
        end
      end

      // Latch expiry
      if (s.pair[p].latch_valid & slow.rise)
      begin
        if (s.pair[p].age == ptimer_pkg::LATCH_LAST)
        begin
          n.pair[p].latch_valid = 1'b0;
        end
        else
        begin
          n.pair[p].age = s.pair[p].age + 6'h01;
        end
      end
    end

    // Read data and read side effects
    for (int i = 0; i < 4; i++)
    begin
      if (idx == ptimer_pkg::IDX_CTL[i])
      begin
        hit = 1'b1;
        rbyte = ctl_byte(s.ctl[i], (i % 2) == 0);
      end
      if (idx == ptimer_pkg::IDX_RLD[i])
      begin
        hit = 1'b1;
        rbyte = s.tmr[i].reload;
      end
      if (idx == ptimer_pkg::IDX_CNT[i])
      begin
        hit = 1'b1;
        rbyte = s.tmr[i].count;
        if (cap & ~pwrite & s.pair[i/2].joined)
        begin
          if ((i % 2) == 0)
          begin
            n.pair[i/2].latch = s.tmr[i+1].count;
            n.pair[i/2].latch_valid = 1'b1;
            n.pair[i/2].age = 6'h00;
          end
          else if (s.pair[i/2].latch_valid)
          begin
            rbyte = s.pair[i/2].latch;
            n.pair[i/2].latch_valid = 1'b0;
          end
        end
      end
    end
    for (int p = 0; p < 2; p++)
    begin
      if (idx == ptimer_pkg::IDX_PAIR[p])
      begin
        hit = 1'b1;
        rbyte[ptimer_pkg::PAIR_JOIN] = s.pair[p].joined;
        rbyte[ptimer_pkg::PAIR_SRC_LO] = s.tmr[2*p].src_sel;
        rbyte[ptimer_pkg::PAIR_SRC_HI] = s.tmr[2*p+1].src_sel;
      end
    end
    if (idx == ptimer_pkg::IDX_PRIO)
    begin
      hit = 1'b1;
      rbyte[ptimer_pkg::PRIO01_POS +: 2] = s.pair[0].prio;
      rbyte[ptimer_pkg::PRIO23_POS +: 2] = s.pair[1].prio;
    end
    if ((idx == ptimer_pkg::IDX_EN_A) || (idx == ptimer_pkg::IDX_EN_B))
    begin
      hit = 1'b1;
      rbyte[ptimer_pkg::IRQ_LO_BIT] = s.tmr[(idx == ptimer_pkg::IDX_EN_B) ? 2 : 0].irq_en;
      rbyte[ptimer_pkg::IRQ_HI_BIT] = s.tmr[(idx == ptimer_pkg::IDX_EN_B) ? 3 : 1].irq_en;
    end
    if ((idx == ptimer_pkg::IDX_FLAG_A) || (idx == ptimer_pkg::IDX_FLAG_B))
    begin
      hit = 1'b1;
      rbyte[ptimer_pkg::IRQ_LO_BIT] = s.tmr[(idx == ptimer_pkg::IDX_FLAG_B) ? 2 : 0].flag;
      rbyte[ptimer_pkg::IRQ_HI_BIT] = s.tmr[(idx == ptimer_pkg::IDX_FLAG_B) ? 3 : 1].flag;
    end
    if (cap)
    begin
      n.prdata = {24'h000000, rbyte};
      n.pslverr = ~hit;
    end

    // Register writes
    if (wr)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (idx == ptimer_pkg::IDX_CTL[i])
        begin
          if ((i % 2) == 0)
          begin
            n.ctl[i].event_mode = wb[ptimer_pkg::CTL_EVENT];
            n.ctl[i].func_sel = wb[ptimer_pkg::CTL_FUNC];
            n.ctl[i].pol_sel = wb[ptimer_pkg::CTL_POL];
          end
          n.ctl[i].ratio = wb[ptimer_pkg::CTL_RATIO +: 2];
          n.ctl[i].repeat_sel = wb[ptimer_pkg::CTL_REPEAT];
          n.ctl[i].run = wb[ptimer_pkg::CTL_RUN];
          if (wb[ptimer_pkg::CTL_PRESET] & ~(((i % 2) == 1) & s.pair[i/2].joined))
          begin
            n.tmr[i].count = s.tmr[i].reload;
            n.tmr[i].div = 6'h00;
            if (((i % 2) == 0) & s.pair[i/2].joined)
            begin
              n.tmr[i+1].count = s.tmr[i+1].reload;
            end
          end
        end
        if (idx == ptimer_pkg::IDX_RLD[i])
        begin
          n.tmr[i].reload = wb;
        end
      end
      for (int p = 0; p < 2; p++)
      begin
        if (idx == ptimer_pkg::IDX_PAIR[p])
        begin
          n.pair[p].joined = wb[ptimer_pkg::PAIR_JOIN];
          n.tmr[2*p].src_sel = wb[ptimer_pkg::PAIR_SRC_LO];
          n.tmr[2*p+1].src_sel = wb[ptimer_pkg::PAIR_SRC_HI];
        end
      end
      if (idx == ptimer_pkg::IDX_PRIO)
      begin
        n.pair[0].prio = wb[ptimer_pkg::PRIO01_POS +: 2];
        n.pair[1].prio = wb[ptimer_pkg::PRIO23_POS +: 2];
      end
      for (int p = 0; p < 2; p++)
      begin
        if (idx == ((p == 0) ? ptimer_pkg::IDX_EN_A : ptimer_pkg::IDX_EN_B))
        begin
          n.tmr[2*p].irq_en = wb[ptimer_pkg::IRQ_LO_BIT];
          n.tmr[2*p+1].irq_en = wb[ptimer_pkg::IRQ_HI_BIT];
        end
        if (idx == ((p == 0) ? ptimer_pkg::IDX_FLAG_A : ptimer_pkg::IDX_FLAG_B))
        begin
          if (wb[ptimer_pkg::IRQ_LO_BIT])
          begin
            n.tmr[2*p].flag = 1'b0;
          end
          if (wb[ptimer_pkg::IRQ_HI_BIT])
          begin
            n.tmr[2*p+1].flag = 1'b0;
          end
        end
      end
    end

    // Underflow sets flags, winning over a clear
    for (int i = 0; i < 4; i++)
    begin
      if (uf[i])
      begin
        n.tmr[i].flag = 1'b1;
      end
    end

    // Joined upper run fixed low; interrupt requests
    for (int p = 0; p < 2; p++)
    begin
      if (n.pair[p].joined)
      begin
        n.ctl[2*p+1].run = 1'b0;
      end
      n.irq_req[p] = (n.pair[p].prio != 2'h0)
        & ((n.tmr[2*p].flag & n.tmr[2*p].irq_en & ~n.pair[p].joined)
        | (n.tmr[2*p+1].flag & n.tmr[2*p+1].irq_en));
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.bus <= ptimer_pkg::BUS_IDLE;
      for (int i = 0; i < 4; i++)
      begin
        s.tmr[i].reload <= ptimer_pkg::RELOAD_RST;
        s.tmr[i].count <= ptimer_pkg::COUNT_RST;
      end
    end
    else
    begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign pready = (s.bus == ptimer_pkg::BUS_ACK);
  assign irq_req = s.irq_req;
  assign irq_level_01 = s.pair[0].prio;
  assign irq_level_23 = s.pair[1].prio;

endmodule : ptimer_quad

/* verification/ptimer_quad_chk.sv */
// Checker: bus handshake and interrupt port relations of the quad timer.
// Assumes binding to ptimer_quad; sees only its ports.
`timescale 1ns/1ps
module ptimer_quad_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ptimer_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic slow_osc_clock,
  input wire logic fast_osc_clock,
  input wire logic event_pin_a,
  input wire logic event_pin_b,
  input wire logic [1:0] irq_req,
  input wire logic [1:0] irq_level_01,
  input wire logic [1:0] irq_level_23
);
  // ==========================================================
  // Helpers
  logic done;
  logic [15:0] idx;
  assign done = psel && penable && pready;
  assign idx = paddr[17:2];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Properties
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
  property p_ready_wait;
    psel && !penable |=> !pready ##1 pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");
  property p_rdata_hi;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("prdata upper bits set");
  property p_unmapped;
    done |-> pslverr == !(idx inside {16'hFF21, 16'hFF23, [16'hFF25:16'hFF27],
      [16'hFF30:16'hFF36], [16'hFF38:16'hFF3E]});
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("pslverr wrong for index");
  property p_prio;
    done && pwrite && idx == ptimer_pkg::IDX_PRIO |=>
      irq_level_01 == $past(pwdata[3:2]) && irq_level_23 == $past(pwdata[5:4]);
  endproperty
  a_prio: assert property (p_prio) else $error("priority level not written");
  property p_irq01;
    irq_req[0] |-> irq_level_01 != 2'h0 || $past(irq_level_01) != 2'h0;
  endproperty
  a_irq01: assert property (p_irq01) else $error("request at level zero");
  property p_irq23;
    irq_req[1] |-> irq_level_23 != 2'h0 || $past(irq_level_23) != 2'h0;
  endproperty
  a_irq23: assert property (p_irq23) else $error("request at level zero");
  property p_preset0;
    done && !pwrite && idx inside {16'hFF31, 16'hFF32, 16'hFF39, 16'hFF3A} |-> !prdata[1];
  endproperty
  a_preset0: assert property (p_preset0) else $error("preset bit read as one");

  // ==========================================================
  // Coverage
  c_err: cover property (done && pslverr);
  c_irq: cover property (irq_req[1]);
  c_lvl: cover property (irq_level_23 == 2'h2);
endmodule : ptimer_quad_chk

bind ptimer_quad ptimer_quad_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .slow_osc_clock, .fast_osc_clock, .event_pin_a,
  .event_pin_b, .irq_req, .irq_level_01, .irq_level_23);

/* verification/ptimer_far_side.sv */
// Far side model: free-running oscillators and event pin drivers.
// Assumes pclk as time base; pin levels are commanded by the bench.
`timescale 1ns/1ps
module ptimer_far_side #(
  parameter int SLOW_HALF = 4,
  parameter int FAST_HALF = 2
) (
  input wire logic pclk,
  input wire logic lvl_a,
  input wire logic lvl_b,
  output logic slow_osc_clock,
  output logic fast_osc_clock,
  output logic event_pin_a,
  output logic event_pin_b
);
  // ==========================================================
  // Oscillators and pins
  int slow_n = 0;
  int fast_n = 0;
  initial slow_osc_clock = 1'b0;
  initial fast_osc_clock = 1'b0;
  initial event_pin_a = 1'b0;
  initial event_pin_b = 1'b0;
  always @(posedge pclk)
  begin
    slow_n <= (slow_n == SLOW_HALF - 1) ? 0 : slow_n + 1;
    fast_n <= (fast_n == FAST_HALF - 1) ? 0 : fast_n + 1;
    if (slow_n == SLOW_HALF - 1)
      slow_osc_clock <= ~slow_osc_clock;
    if (fast_n == FAST_HALF - 1)
      fast_osc_clock <= ~fast_osc_clock;
    event_pin_a <= lvl_a;
    event_pin_b <= lvl_b;
  end
endmodule : ptimer_far_side

/* verification/ptimer_quad_bench.sv */
// Testbench: register-level tests of the quad timer over APB.
// Assumes slow oscillator period 8 pclk, fast 4 pclk.
`timescale 1ns/1ps
module ptimer_quad_bench;
  // ==========================================================
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ptimer_pkg::ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, slow_osc_clock, fast_osc_clock, event_pin_a, event_pin_b;
  logic [1:0] irq_req, irq_level_01, irq_level_23;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  logic [7:0] rd_q;
  logic err_q;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int r, e;

  always #2 pclk = ~pclk;

  ptimer_quad u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .slow_osc_clock, .fast_osc_clock, .event_pin_a, .event_pin_b,
    .irq_req, .irq_level_01, .irq_level_23);
  ptimer_far_side u_far (.pclk, .lvl_a, .lvl_b, .slow_osc_clock, .fast_osc_clock,
    .event_pin_a, .event_pin_b);

  // ==========================================================
  // Tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd_q = prdata[7:0];
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input logic [7:0] got);
    samples_checked++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input string what);
    xfer(1'b0, idx, 8'h00);
    chk(what, exp, rd_q);
  endtask : rdc

  task automatic pin_b(input logic v, input int n);
    @(posedge pclk);
    lvl_b <= v;
    repeat (n) @(posedge pclk);
  endtask : pin_b

  task automatic wait_flag(input logic [15:0] idx, input logic [7:0] m);
    rd_q = 8'h00;
    for (int k = 0; k < 1500 && (rd_q & m) == 8'h00; k++)
      xfer(1'b0, idx, 8'h00);
    chk("flag", m, rd_q & m);
  endtask : wait_flag

  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      rdc(ptimer_pkg::IDX_CTL[k], 8'h00, "ctl");
      rdc(ptimer_pkg::IDX_RLD[k], 8'hFF, "reload");
      rdc(ptimer_pkg::IDX_CNT[k], 8'hFF, "count");
    end
    rdc(ptimer_pkg::IDX_PAIR[0], 8'h00, "pair");
    rdc(ptimer_pkg::IDX_PAIR[1], 8'h00, "pair");
    rdc(ptimer_pkg::IDX_PRIO, 8'h00, "prio");
    rdc(ptimer_pkg::IDX_EN_A, 8'h00, "en");
    rdc(ptimer_pkg::IDX_EN_B, 8'h00, "en");
    rdc(ptimer_pkg::IDX_FLAG_A, 8'h00, "flag");
    xfer(1'b0, 16'hFF22, 8'h00);
    chk("err", 8'h01, {7'h0, err_q});
    xfer(1'b1, ptimer_pkg::IDX_CNT[3], 8'h12);
    rdc(ptimer_pkg::IDX_CNT[3], 8'hFF, "count");
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      r = (i < 4) ? i : 1;
      xfer(1'b1, ptimer_pkg::IDX_PAIR[0], (i < 4) ? 8'h02 : 8'h00);
      xfer(1'b1, ptimer_pkg::IDX_CTL[1], 8'(r * 8 + 2));
      xfer(1'b1, ptimer_pkg::IDX_CTL[1], 8'(r * 8 + 1));
      repeat (512) @(posedge pclk);
      xfer(1'b1, ptimer_pkg::IDX_CTL[1], 8'h00);
      xfer(1'b0, ptimer_pkg::IDX_CNT[1], 8'h00);
      e = 255 - ((128 >> (2 * r)) >> ((i < 4) ? 0 : 1));
      chk_rng("ratio", e - 2, e + 2, rd_q);
    end
    $display("test prescaler done");
    xfer(1'b1, ptimer_pkg::IDX_PAIR[0], 8'h01);
    xfer(1'b1, ptimer_pkg::IDX_CTL[0], 8'h63);
    repeat (100) @(posedge pclk);
    rdc(ptimer_pkg::IDX_CNT[0], 8'hFF, "width");
    @(posedge pclk);
    lvl_a <= 1'b1;
    repeat (100) @(posedge pclk);
    lvl_a <= 1'b0;
    repeat (20) @(posedge pclk);
    xfer(1'b0, ptimer_pkg::IDX_CNT[0], 8'h00);
    chk_rng("width", 226, 234, rd_q);
    xfer(1'b1, ptimer_pkg::IDX_CTL[0], 8'h00);
    $display("test pulse width done");
    xfer(1'b1, ptimer_pkg::IDX_RLD[0], 8'h02);
    xfer(1'b1, ptimer_pkg::IDX_RLD[1], 8'h05);
    xfer(1'b1, ptimer_pkg::IDX_PAIR[0], 8'h12);
    xfer(1'b1, ptimer_pkg::IDX_CTL[0], 8'h1F);
    wait_flag(ptimer_pkg::IDX_FLAG_A, 8'h40);
    xfer(1'b1, ptimer_pkg::IDX_CTL[0], 8'h18);
    rdc(ptimer_pkg::IDX_CNT[0], 8'h02, "low");
    rdc(ptimer_pkg::IDX_CNT[1], 8'h04, "high");
    xfer(1'b1, ptimer_pkg::IDX_CTL[1], 8'h02);
    rdc(ptimer_pkg::IDX_CNT[1], 8'h04, "high");
    xfer(1'b1, ptimer_pkg::IDX_PRIO, 8'h04);
    xfer(1'b1, ptimer_pkg::IDX_EN_A, 8'h40);
    settle();
    chk("irq", 8'h00, {7'h0, irq_req[0]});
    chk("level", 8'h01, {6'h0, irq_level_01});
    xfer(1'b1, ptimer_pkg::IDX_PAIR[0], 8'h00);
    settle();
    chk("irq", 8'h01, {7'h0, irq_req[0]});
    xfer(1'b1, ptimer_pkg::IDX_FLAG_A, 8'hC0);
    $display("test joined done");
    xfer(1'b1, ptimer_pkg::IDX_PAIR[1], 8'h01);
    xfer(1'b1, ptimer_pkg::IDX_RLD[2], 8'h0A);
    xfer(1'b1, ptimer_pkg::IDX_CTL[2], 8'hBB);
    pin_b(1'b1, 20);
    rdc(ptimer_pkg::IDX_CNT[2], 8'h09, "event");
    pin_b(1'b0, 20);
    rdc(ptimer_pkg::IDX_CNT[2], 8'h09, "event");
    xfer(1'b1, ptimer_pkg::IDX_CTL[2], 8'h83);
    pin_b(1'b1, 20);
    rdc(ptimer_pkg::IDX_CNT[2], 8'h0A, "event");
    pin_b(1'b0, 20);
    rdc(ptimer_pkg::IDX_CNT[2], 8'h09, "event");
    xfer(1'b1, ptimer_pkg::IDX_CTL[2], 8'hE3);
    pin_b(1'b1, 40);
    pin_b(1'b0, 400);
    rdc(ptimer_pkg::IDX_CNT[2], 8'h0A, "filter");
    pin_b(1'b1, 600);
    pin_b(1'b0, 300);
    rdc(ptimer_pkg::IDX_CNT[2], 8'h09, "filter");
    xfer(1'b1, ptimer_pkg::IDX_CTL[2], 8'h00);
    $display("test event done");
    xfer(1'b1, ptimer_pkg::IDX_PAIR[1], 8'h00);
    xfer(1'b1, ptimer_pkg::IDX_RLD[3], 8'h03);
    xfer(1'b1, ptimer_pkg::IDX_CTL[3], 8'h03);
    wait_flag(ptimer_pkg::IDX_FLAG_B, 8'h80);
    rdc(ptimer_pkg::IDX_CTL[3], 8'h00, "ctl");
    rdc(ptimer_pkg::IDX_CNT[3], 8'h03, "count");
    chk("irq", 8'h00, {7'h0, irq_req[1]});
    xfer(1'b1, ptimer_pkg::IDX_PRIO, 8'h20);
    settle();
    chk("irq", 8'h00, {7'h0, irq_req[1]});
    xfer(1'b1, ptimer_pkg::IDX_EN_B, 8'h80);
    settle();
    chk("irq", 8'h01, {7'h0, irq_req[1]});
    chk("level", 8'h02, {6'h0, irq_level_23});
    xfer(1'b1, ptimer_pkg::IDX_FLAG_B, 8'h00);
    rdc(ptimer_pkg::IDX_FLAG_B, 8'h80, "flag");
    xfer(1'b1, ptimer_pkg::IDX_FLAG_B, 8'h80);
    rdc(ptimer_pkg::IDX_FLAG_B, 8'h00, "flag");
    settle();
    chk("irq", 8'h00, {7'h0, irq_req[1]});
    xfer(1'b1, ptimer_pkg::IDX_CTL[3], 8'h07);
    repeat (200) @(posedge pclk);
    rdc(ptimer_pkg::IDX_CTL[3], 8'h05, "ctl");
    xfer(1'b1, ptimer_pkg::IDX_CTL[3], 8'h00);
    $display("test one shot done");
    end_sim();
  end
endmodule : ptimer_quad_bench
